// *** rtl/pis_pkg.sv ***
package pis_pkg;

  // ---------------------------------------------------------------
  // operand geometry
  // ---------------------------------------------------------------
  localparam int WIDE_BITS   = 128;
  localparam int NARROW_BITS = 64;
  localparam int MUL_KEEP    = 18;   // bits kept of each product
  localparam int ZERO_BIT    = 7;    // control byte zeroing bit

  // ---------------------------------------------------------------
  // control and feature bit positions
  // ---------------------------------------------------------------
  localparam int EMULATION_FLAG_POS    = 2;
  localparam int TASK_SWITCHED_FLAG_POS    = 3;
  localparam int NUMERIC_ERROR_FLAG_POS    = 5;
  localparam int ECX_SE3_POS   = 0;
  localparam int ECX_SUPP_POS  = 9;

  // ---------------------------------------------------------------
  // fault vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_UD   = 8'h06;
  localparam logic [7:0] VEC_NM   = 8'h07;
  localparam logic [7:0] VEC_SIMD = 8'h13;
  localparam logic [7:0] VEC_MF   = 8'h10;

  typedef enum logic [2:0] {
    PIS_OP_MULHRS,
    PIS_OP_SHUF,
    PIS_OP_SIGN,
    PIS_OP_ALIGN,
    PIS_OP_SE3_NUM,   // numeric-reporting extension op
    PIS_OP_TRUNC_ST   // truncating store to integer
  } pis_op_t;

  typedef enum logic [1:0] {
    PIS_LANE_8,
    PIS_LANE_16,
    PIS_LANE_32
  } pis_lane_t;

  typedef struct packed {
    logic        valid;
    pis_op_t     op;
    pis_lane_t   lane;
    logic        wide;     // 1: 128-bit form
    logic [7:0]  imm;
    logic [127:0] dst;
    logic [127:0] src;
  } pis_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [7:0]  vector;
    logic [127:0] result;
  } pis_rsp_t;

endpackage

// *** rtl/pis_simd_unit.sv ***
// Overview of operation
// - each op has 128-bit and 64-bit forms
// - signed 16x16 lane product to 32 bits
// - keep top 18 bits of product
// - always add one at 18-bit lsb
// - result is 16 bits below top bit
// - shuffle index from low control bits
// - control bit 7 set zeroes byte
// - control operand stays unchanged
// - negate lane when source negative
// - destination above source in composite
// - extract at immediate byte offset
// - task switched flag raises unavailable fault
// - missing extension support gives invalid opcode
// - numeric error flag and pin ignored
// - integer ops raise no float errors
// - emulation flag gives invalid opcode
// - report feature bit 9 set
// - numeric errors use vector 19, store legacy
`timescale 1ns/1ps
`default_nettype none

module pis_simd_unit #(
  parameter int OPW = 128
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire pis_pkg::pis_req_t req,
  input  wire logic [31:0]       cr0,
  input  wire logic              se3_supported,
  input  wire logic              ignore_numeric_error_pin,
  input  wire logic              numeric_error_pending,
  output var  pis_pkg::pis_rsp_t rsp,
  output logic [31:0]            feature_ecx
);

  // the lane loops below are sized for the wide form only
  if (OPW != pis_pkg::WIDE_BITS) begin : g_bad_width
    $error("OPW must equal the wide operand width");
  end

  // ---------------------------------------------------------------
  // fault checks
  // ---------------------------------------------------------------
  logic       fault;
  logic [7:0] fault_vec;
  logic       is_se3_op;

  // priority: missing support, then emulation, then task switched
  always_comb begin
    fault     = 1'b0;
    fault_vec = 8'h00;
    is_se3_op = (req.op == pis_pkg::PIS_OP_SE3_NUM) || (req.op == pis_pkg::PIS_OP_TRUNC_ST);
    if (is_se3_op && !se3_supported) begin
      fault     = 1'b1;
      fault_vec = pis_pkg::VEC_UD;
    end else if (cr0[pis_pkg::EMULATION_FLAG_POS]) begin
      fault     = 1'b1;
      fault_vec = pis_pkg::VEC_UD;
    end else if (cr0[pis_pkg::TASK_SWITCHED_FLAG_POS]) begin
      fault     = 1'b1;
      fault_vec = pis_pkg::VEC_NM;
    end else if (is_se3_op && numeric_error_pending) begin
      // numeric error flag and ignore pin never consulted here
      fault     = 1'b1;
      fault_vec = (req.op == pis_pkg::PIS_OP_TRUNC_ST) ? pis_pkg::VEC_MF : pis_pkg::VEC_SIMD;
    end
    // integer lane ops never reach the numeric branch
    if (!is_se3_op && !fault) fault_vec = 8'h00;
  end

  // ---------------------------------------------------------------
  // multiply high with round and scale
  // ---------------------------------------------------------------
  logic [127:0] mul_res;

  always_comb begin
    logic signed [31:0] prod;
    logic [17:0]        top;
    prod = '0;
    top  = '0;
    mul_res = '0;
    for (int i = 0; i < 8; i++) begin
      prod = $signed(req.dst[i*16 +: 16]) * $signed(req.src[i*16 +: 16]);
      top  = prod[31 -: pis_pkg::MUL_KEEP];
      top  = top + 18'h00001;
      mul_res[i*16 +: 16] = top[16:1];
    end
  end

  // ---------------------------------------------------------------
  // byte shuffle, sign, align
  // ---------------------------------------------------------------
  logic [127:0] shuf_res;
  logic [127:0] sign_res;
  logic [127:0] align_res;

  // src is only read, dst alone takes the permuted bytes
  always_comb begin
    logic [3:0] idx;
    idx = '0;
    shuf_res = '0;
    for (int i = 0; i < 16; i++) begin
      idx = req.wide ? req.src[i*8 +: 4] : {1'b0, req.src[i*8 +: 3]};
      if (req.src[i*8 + pis_pkg::ZERO_BIT]) begin
        shuf_res[i*8 +: 8] = 8'h00;
      end else begin
        shuf_res[i*8 +: 8] = req.dst[idx*8 +: 8];
      end
    end
  end

  // lanes taken at the requested width, negative negates, zero clears
  always_comb begin
    sign_res = '0;
    unique case (req.lane)
      pis_pkg::PIS_LANE_8:
        for (int i = 0; i < 16; i++) begin
          if (req.src[i*8+7]) sign_res[i*8 +: 8] = 8'h00 - req.dst[i*8 +: 8];
          else if (req.src[i*8 +: 8] == 8'h00) sign_res[i*8 +: 8] = 8'h00;
          else sign_res[i*8 +: 8] = req.dst[i*8 +: 8];
        end
      pis_pkg::PIS_LANE_16:
        for (int i = 0; i < 8; i++) begin
          if (req.src[i*16+15]) sign_res[i*16 +: 16] = 16'h0000 - req.dst[i*16 +: 16];
          else if (req.src[i*16 +: 16] == 16'h0000) sign_res[i*16 +: 16] = 16'h0000;
          else sign_res[i*16 +: 16] = req.dst[i*16 +: 16];
        end
      default:
        for (int i = 0; i < 4; i++) begin
          if (req.src[i*32+31]) sign_res[i*32 +: 32] = 32'h00000000 - req.dst[i*32 +: 32];
          else if (req.src[i*32 +: 32] == 32'h00000000) sign_res[i*32 +: 32] = 32'h00000000;
          else sign_res[i*32 +: 32] = req.dst[i*32 +: 32];
        end
    endcase
  end

  // oversize offsets shift in zeros, as a plain wide shift does
  always_comb begin
    logic [255:0] comp;
    logic [127:0] comp_n;
    comp   = {req.dst, req.src};
    comp_n = {req.dst[63:0], req.src[63:0]};
    if (req.wide) begin
      align_res = 128'(comp >> ({3'b000, req.imm} * 11'd8));
    end else begin
      align_res = {64'h0, 64'(comp_n >> ({3'b000, req.imm} * 11'd8))};
    end
  end

  // ---------------------------------------------------------------
  // result select and output registers
  // ---------------------------------------------------------------
  logic [127:0] sel;

  always_comb begin
    unique case (req.op)
      pis_pkg::PIS_OP_MULHRS: sel = mul_res;
      pis_pkg::PIS_OP_SHUF:   sel = shuf_res;
      pis_pkg::PIS_OP_SIGN:   sel = sign_res;
      pis_pkg::PIS_OP_ALIGN:  sel = align_res;
      default:                sel = req.dst;
    endcase
    if (!req.wide) sel = {64'h0, sel[63:0]};
  end

  // one-cycle latency; fault suppresses the result
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.valid  <= req.valid;
      rsp.fault  <= req.valid && fault;
      rsp.vector <= (req.valid && fault) ? fault_vec : 8'h00;
      rsp.result <= (req.valid && !fault) ? sel : 128'h0;
    end
  end

  // feature word: only the two extension bits are driven here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      feature_ecx <= 32'h00000000;
    end else begin
      feature_ecx <= 32'h00000000;
      feature_ecx[pis_pkg::ECX_SUPP_POS]  <= 1'b1;
      feature_ecx[pis_pkg::ECX_SE3_POS]   <= se3_supported;
    end
  end

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  // reference forms written apart from the datapath, so that a slip in
  // one cannot hide behind the same slip in the other
  logic [31:0] mul_chk0;
  logic [15:0] mul_exp0;
  logic [7:0]  shuf_exp0;
  logic [7:0]  sign_exp0;
  logic [31:0] sign32_exp0;

  // half an lsb added before the cut is the same as rounding the kept bits
  assign mul_chk0  = 32'($signed(req.dst[15:0]) * $signed(req.src[15:0])) + 32'h00004000;
  assign mul_exp0  = mul_chk0[30:15];
  // lane 0 only: byte index scaled by concatenation instead of a product
  assign shuf_exp0 = req.wide ? req.dst[{req.src[3:0], 3'b000} +: 8] : req.dst[{req.src[2:0], 3'b000} +: 8];
  assign sign_exp0 = req.src[7] ? ~req.dst[7:0] + 8'h01 : ((req.src[7:0] == 8'h00) ? 8'h00 : req.dst[7:0]);
  assign sign32_exp0 = req.src[31] ? ~req.dst[31:0] + 32'h00000001 :
                       ((req.src[31:0] == 32'h00000000) ? 32'h00000000 : req.dst[31:0]);

  // ---------------------------------------------------------------
  // assertion sequences
  // ---------------------------------------------------------------
  // a request that has passed every fault check
  sequence s_clean_take;
    req.valid && !fault;
  endsequence

  // the answer that carries data rather than a fault
  sequence s_data_answer;
    rsp.valid && !rsp.fault && (rsp.vector == 8'h00);
  endsequence

  // a numeric-reporting op with support present and both control flags clear
  sequence s_numeric_take;
    req.valid && is_se3_op && se3_supported && !cr0[pis_pkg::EMULATION_FLAG_POS] && !cr0[pis_pkg::TASK_SWITCHED_FLAG_POS];
  endsequence

  // ---------------------------------------------------------------
  // fault assertions
  // ---------------------------------------------------------------
  // control flags in priority order; emulation outranks task switched
  a_ts_fault_vec: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && cr0[pis_pkg::TASK_SWITCHED_FLAG_POS] && !cr0[pis_pkg::EMULATION_FLAG_POS] && !(is_se3_op && !se3_supported)
    |=> rsp.fault && (rsp.vector == pis_pkg::VEC_NM))
    else $error("task switched did not give the unavailable vector");
  a_em_fault_vec: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && cr0[pis_pkg::EMULATION_FLAG_POS] |=> rsp.fault && (rsp.vector == pis_pkg::VEC_UD))
    else $error("emulation did not give the invalid opcode vector");
  a_nosup_fault: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && is_se3_op && !se3_supported |=> rsp.fault && (rsp.vector == pis_pkg::VEC_UD))
    else $error("unsupported op not invalid opcode");
  a_fault_clear: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && fault |=> rsp.fault && (rsp.result == 128'h0))
    else $error("faulting request left a result");

  // numeric reporting; the error flag and ignore pin are never inputs here
  a_ne_ignored: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !cr0[pis_pkg::TASK_SWITCHED_FLAG_POS] && !cr0[pis_pkg::EMULATION_FLAG_POS] && !is_se3_op |=> !rsp.fault)
    else $error("integer op faulted with clear flags");
  a_num_vec19: assert property (@(posedge core_clk) disable iff (rst)
    s_numeric_take ##0 (req.op == pis_pkg::PIS_OP_SE3_NUM && numeric_error_pending)
    |=> rsp.fault && (rsp.vector == pis_pkg::VEC_SIMD))
    else $error("numeric error not on the extension vector");
  a_trunc_legacy: assert property (@(posedge core_clk) disable iff (rst)
    s_numeric_take ##0 (req.op == pis_pkg::PIS_OP_TRUNC_ST && numeric_error_pending)
    |=> rsp.fault && (rsp.vector == pis_pkg::VEC_MF))
    else $error("truncating store error not on the legacy vector");
  a_pin_ignored: assert property (@(posedge core_clk) disable iff (rst)
    s_numeric_take ##0 !numeric_error_pending |=> s_data_answer)
    else $error("error flag or ignore pin changed the outcome");

  // feature word, checked one edge after reset lets go
  a_feat_bit9: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> feature_ecx[pis_pkg::ECX_SUPP_POS])
    else $error("feature support bit clear");
  a_feat_bit0: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> feature_ecx[pis_pkg::ECX_SE3_POS] == $past(se3_supported))
    else $error("extension support bit does not follow its input");

  // ---------------------------------------------------------------
  // datapath assertions
  // ---------------------------------------------------------------
  // lane 0 of multiply, shuffle and byte and dword sign against the reference forms above; align only past the composite
  a_mul_lane0: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_MULHRS) |=> s_data_answer ##0 (rsp.result[15:0] == $past(mul_exp0)))
    else $error("multiply lane 0 wrong");
  a_shuf_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_SHUF && req.src[pis_pkg::ZERO_BIT])
    |=> s_data_answer ##0 (rsp.result[7:0] == 8'h00))
    else $error("shuffle zero bit ignored");
  a_shuf_pick: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_SHUF && !req.src[pis_pkg::ZERO_BIT])
    |=> s_data_answer ##0 (rsp.result[7:0] == $past(shuf_exp0)))
    else $error("shuffle picked the wrong byte");
  a_sign_byte0: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_SIGN && req.lane == pis_pkg::PIS_LANE_8)
    |=> s_data_answer ##0 (rsp.result[7:0] == $past(sign_exp0)))
    else $error("byte sign lane 0 wrong");
  a_sign_dword0: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_SIGN && req.lane == pis_pkg::PIS_LANE_32)
    |=> s_data_answer ##0 (rsp.result[31:0] == $past(sign32_exp0)))
    else $error("dword sign lane 0 wrong");
  a_align_far: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_take ##0 (req.op == pis_pkg::PIS_OP_ALIGN && req.imm >= (req.wide ? 8'h20 : 8'h10))
    |=> s_data_answer ##0 (rsp.result == 128'h0))
    else $error("align past the composite did not give zero");

  // response framing: one answer per request, nothing in idle cycles
  a_rsp_valid: assert property (@(posedge core_clk) disable iff (rst)
    req.valid |=> rsp.valid)
    else $error("request gave no answer");
  a_rsp_idle: assert property (@(posedge core_clk) disable iff (rst)
    !req.valid |=> !rsp.valid && !rsp.fault && (rsp.result == 128'h0))
    else $error("answer without a request");
  a_narrow_top: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !req.wide |=> rsp.result[127:64] == 64'h0)
    else $error("narrow form upper half not clear");

endmodule // pis_simd_unit

`default_nettype wire

// *** verification/pis_dec_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// decode and control-register side
// ------------------------------------------------
module pis_dec_model (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire pis_pkg::pis_req_t cmd,
  input  wire logic [34:0]       ctl_in,
  output var  pis_pkg::pis_req_t req,
  output var  logic [34:0]       ctl
);
  // request and control bits launch on the same edge so they always agree
  always_ff @(posedge core_clk) begin
    req <= rst ? '0 : cmd;
    ctl <= rst ? '0 : ctl_in;
  end
endmodule // pis_dec_model

`default_nettype wire

// *** verification/pis_simd_unit_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module pis_simd_unit_bench;
  typedef struct packed {logic chk; pis_pkg::pis_rsp_t r;} pis_exp_t;
  logic              core_clk;
  logic              rst;
  pis_pkg::pis_req_t cmd;
  pis_pkg::pis_req_t req;
  logic [34:0]       ctl_in;
  logic [34:0]       ctl;
  pis_pkg::pis_rsp_t rsp;
  logic [31:0]       feature_ecx;
  logic [31:0]       seed;
  pis_exp_t          exp_q[$];
  int                fail_count;
  int                check_count;

  // ------------------------------------------------
  // clock, partner and design
  // ------------------------------------------------
  always #20 core_clk = ~core_clk;
  pis_dec_model pis_dec_model_i (.core_clk(core_clk), .rst(rst), .cmd(cmd), .ctl_in(ctl_in), .req(req), .ctl(ctl));
  pis_simd_unit pis_simd_unit_i (.core_clk(core_clk), .rst(rst), .req(req), .cr0(ctl[31:0]), .se3_supported(ctl[32]),
    .ignore_numeric_error_pin(ctl[33]), .numeric_error_pending(ctl[34]), .rsp(rsp), .feature_ecx(feature_ecx));

  // ------------------------------------------------
  // reference arithmetic
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [127:0] calc(pis_pkg::pis_req_t r);
    logic [255:0] comp;
    logic [127:0] res, m, dv, sv;
    logic [31:0]  p;
    logic [17:0]  t;
    logic [7:0]   c;
    int           w;
    res = '0;
    case (r.op)
      pis_pkg::PIS_OP_MULHRS: for (int i = 0; i < 8; i++) begin
        p = $signed(r.dst[i*16+:16]) * $signed(r.src[i*16+:16]);
        t = p[31:14] + 18'h1;
        res[i*16+:16] = t[16:1];
      end
      pis_pkg::PIS_OP_SHUF: for (int i = 0; i < 16; i++) begin
        c = r.src[i*8+:8];
        res[i*8+:8] = c[7] ? 8'h00 : r.dst[(r.wide ? c[3:0] : {1'b0, c[2:0]})*8+:8];
      end
      pis_pkg::PIS_OP_SIGN: begin
        w = 8 << r.lane;
        m = (128'h1 << w) - 128'h1;
        for (int i = 0; i < 128; i += w) begin
          dv = (r.dst >> i) & m;
          sv = (r.src >> i) & m;
          if (sv[w-1]) dv = (~dv + 128'h1) & m;
          else if (sv == '0) dv = '0;
          res |= dv << i;
        end
      end
      pis_pkg::PIS_OP_ALIGN: begin
        comp = r.wide ? {r.dst, r.src} : {128'h0, r.dst[63:0], r.src[63:0]};
        comp = comp >> {r.imm, 3'h0};
        res = comp[127:0];
      end
      default: ;
    endcase
    if (!r.wide) res[127:64] = '0;
    return res;
  endfunction

  // notes the expected answer, then launches the request for one cycle
  task automatic issue(input pis_pkg::pis_req_t r, input logic [34:0] k);
    pis_exp_t e;
    logic     s3;
    s3 = r.op inside {pis_pkg::PIS_OP_SE3_NUM, pis_pkg::PIS_OP_TRUNC_ST};
    e = '0;
    e.r.valid = 1'b1;
    e.r.fault = 1'b1;
    if (s3 && !k[32]) e.r.vector = pis_pkg::VEC_UD;
    else if (k[pis_pkg::EMULATION_FLAG_POS]) e.r.vector = pis_pkg::VEC_UD;
    else if (k[pis_pkg::TASK_SWITCHED_FLAG_POS]) e.r.vector = pis_pkg::VEC_NM;
    else if (s3 && k[34]) e.r.vector = (r.op == pis_pkg::PIS_OP_TRUNC_ST) ? pis_pkg::VEC_MF : pis_pkg::VEC_SIMD;
    else e.r.fault = 1'b0;
    e.chk = !s3 || e.r.fault;
    e.r.result = e.r.fault ? '0 : calc(r);
    exp_q.push_back(e);
    cmd <= r;
    ctl_in <= k;
    @(posedge core_clk);
  endtask

  task automatic cmp(input string nm, input logic [127:0] ex, input logic [127:0] got);
    check_count++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------
  // checking and stimulus
  // ------------------------------------------------
  // answers pop the oldest note; a stray answer counts as a miss
  always @(posedge core_clk) begin
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) cmp("stray", 128'h0, 128'h1);
      else begin
        pis_exp_t e;
        e = exp_q.pop_front();
        cmp("fault", {119'h0, e.r.fault, e.r.vector}, {119'h0, rsp.fault, rsp.vector});
        if (e.chk) cmp("result", e.r.result, rsp.result);
      end
    end
  end

  // sized for the 600-request run plus slack
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    pis_pkg::pis_req_t r;
    logic [31:0]       a;
    core_clk = 1'b0;
    rst = 1'b1;
    cmd = '0;
    ctl_in = '0;
    seed = 32'hF2250BB8;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    cmp("ecx_rst", 128'h0, {96'h0, feature_ecx});
    cmp("rsp_rst", 128'h0, rsp.result | {126'h0, rsp.valid, rsp.fault});
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmp("ecx", 128'h200, {96'h0, feature_ecx});
    r = '0;
    r.valid = 1'b1;
    r.wide = 1'b1;
    r.dst = {8{16'h8000}};
    r.src = {8{16'h8000}};
    issue(r, 35'h1_0000_0000);
    for (int n = 0; n < 600; n++) begin
      a = rnd();
      r.op = pis_pkg::pis_op_t'(a[2:0] > 3'h5 ? 3'h3 : a[2:0]);
      r.lane = pis_pkg::pis_lane_t'(a[4:3] == 2'h3 ? 2'h0 : a[4:3]);
      r.wide = a[5];
      r.imm = {2'h0, a[11:6]};
      r.dst = {rnd(), rnd(), rnd(), rnd()};
      r.src = {rnd(), rnd(), rnd(), rnd()};
      a = rnd();
      // 34 pending, 33 pin, 32 support, 5 error flag, 3 task switched, 2 emulation
      issue(r, {a[31:30], a[29:27] != 3'h0, 26'h0, a[5], 1'b0, a[3] & a[4], a[2] & a[1], 2'h0});
    end
    cmd <= '0;
    repeat (4) @(posedge core_clk);
    cmp("ecx", {96'h0, 32'h200 | {31'h0, ctl[32]}}, {96'h0, feature_ecx});
    // a second reset in mid-run must clear both outputs, then serve at once
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp("ecx_rst", 128'h0, {96'h0, feature_ecx});
    cmp("rsp_rst", 128'h0, rsp.result | {126'h0, rsp.valid, rsp.fault});
    rst <= 1'b0;
    issue(r, 35'h1_0000_0000);
    cmd <= '0;
    repeat (4) @(posedge core_clk);
    cmp("queue", 128'h0, 128'(exp_q.size()));
    print_verdict();
  end
endmodule // pis_simd_unit_bench

`default_nettype wire
